/* touch_seq_pkg.sv */
// constants and types for the touch screen conversion sequencer
// assumes a single 250 MHz clock and a word-wide register port behind the serial interface
package touch_seq_pkg;

  // ****************************************
  // register locations (word index)
  // ****************************************
  localparam logic [3:0] ADDR_SPARE        = 4'h0;
  localparam logic [3:0] ADDR_PRIMARY      = 4'h1;
  localparam logic [3:0] ADDR_SECONDARY    = 4'h2;
  localparam logic [3:0] ADDR_LIMIT_SELECT = 4'h3;
  localparam logic [3:0] ADDR_LAST_RW      = 4'h7;
  localparam logic [3:0] ADDR_Y_RESULT     = 4'h8;
  localparam logic [3:0] ADDR_X_RESULT     = 4'h9;
  localparam logic [3:0] ADDR_P1_RESULT    = 4'hA;
  localparam logic [3:0] ADDR_P2_RESULT    = 4'hB;
  localparam logic [3:0] ADDR_ANALOG_RES   = 4'hC;
  localparam logic [3:0] ADDR_THERMAL_RES  = 4'hD;
  localparam logic [3:0] ADDR_PART_CODE    = 4'hE;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] RESET_ZERO      = 16'h0000;
  localparam logic [15:0] RESET_SECONDARY = 16'h4040;
  // arbitrary neutral identity value
  localparam logic [15:0] PART_CODE_VALUE = 16'h0A5C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int PRI_LIMIT_IRQ_EN = 15;   // 1 = limit interrupt function on
  localparam int PRI_CHAN_LSB     = 12;   // manual channel [14:12]
  localparam int PRI_MODE_LSB     = 10;   // conversion mode [11:10]
  localparam int PRI_ACQ_LSB      = 8;    // sample window [9:8]
  localparam int PRI_TIMER_LSB    = 0;    // interval timer [7:0]
  localparam int SEC_PIN_FUNC     = 13;
  localparam int SEC_PIN_DATA     = 12;
  localparam int SEC_PIN_DIR      = 11;
  localparam int SEC_PIN_POL      = 10;
  localparam int SEC_RANK_LSB     = 5;    // rank filter depth [6:5]
  localparam int SEC_SETTLE_LSB   = 0;    // settling delay [3:0]
  localparam int LIM_PIN_IRQ_OFF  = 12;   // 1 = pin may not raise interrupt
  localparam int LIM_CHAN_LSB     = 1;    // sequence channel mask [7:1]

  // ****************************************
  // modes and channel codes
  // ****************************************
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_MASTER = 2'h3;
  localparam logic [2:0] CHAN_NONE    = 3'h0;
  localparam logic [2:0] CHAN_THERMAL = 3'h1;
  localparam logic [2:0] CHAN_PRESS2  = 3'h4;

  // ****************************************
  // timing, counted in half-microsecond ticks
  // ****************************************
  localparam int CLK_PERIOD_NS  = 4;
  localparam int TICK_NS        = 500;
  localparam int TICK_CYCLES    = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_BASE_NS    = 2000;
  localparam int CONV_NS        = 7500;
  localparam int SORT_NS        = 2000;
  localparam int THERMAL_ACQ_NS = 16000;
  localparam int SETTLE_STEP_NS = 128000;
  localparam int TIMER_STEP_NS  = 36500;
  localparam int ACQ_BASE_TICKS    = ACQ_BASE_NS / TICK_NS;
  localparam int CONV_TICKS        = CONV_NS / TICK_NS;
  localparam int SORT_TICKS        = SORT_NS / TICK_NS;
  localparam int THERMAL_ACQ_TICKS = THERMAL_ACQ_NS / TICK_NS;
  localparam int SETTLE_STEP_TICKS = SETTLE_STEP_NS / TICK_NS;
  localparam int TIMER_STEP_TICKS  = TIMER_STEP_NS / TICK_NS;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE, S_SETTLE, S_ACQ, S_CONV, S_SORT, S_END_SETTLE, S_TIMER
  } seq_state_t;

  typedef struct packed {
    logic [15:0][15:0] regs;      // register words, index 15 unused
    logic              pin_meta;  // first synchroniser stage
    logic              pin_sync;  // second synchroniser stage
    logic              pin_prev;  // last synchronised level
    logic              func_prev; // last pin-function enable
    logic              irq_hold;  // pin interrupt latched
    logic              int_n;
    logic              gpio_out;
    logic              gpio_oe;
    logic [15:0]       rdata;
    logic              rvalid;
    seq_state_t        state;
    logic [6:0]        tick_cnt;
    logic              tick;
    logic [15:0]       wait_cnt;
    logic [7:1]        pending;
    logic [2:0]        chan;
    logic [3:0]        sample;
    logic              conv_start;
    logic [2:0]        conv_channel;
    logic              busy;
  } seq_regs_t;

endpackage

/* touch_seq.sv */
// register map, pin interrupt and conversion sequencer timing of the touch controller
// assumes a serial front end delivering word accesses on clk, and a converter
// core that returns adc_data on clk by the end of each conversion window
`timescale 1ns/1ps

module touch_seq
  import touch_seq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  reg_addr,      // word index
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,        // one-cycle write strobe
  input  wire logic        reg_rd,        // one-cycle read strobe
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        gpio_in,       // pin level, asynchronous
  output logic             gpio_out,
  output logic             gpio_oe,
  input  wire logic [11:0] adc_data,      // converter result, same clock
  output logic             conv_start,
  output logic      [2:0]  conv_channel,
  output logic             seq_busy,
  output logic             int_n          // active-low interrupt
);

  // ****************************************
  // helpers
  // ****************************************

  // highest enabled channel code, none when mask empty
  function automatic logic [2:0] top_channel(input logic [7:1] mask);
    logic [2:0] code;
    code = CHAN_NONE;
    for (int k = 1; k <= 7; k++)
      if (mask[k])
        code = 3'(k);
    return code;
  endfunction
  // result word index for a channel code
  function automatic logic [3:0] result_index(input logic [2:0] code);
    logic [3:0] idx;
    idx = ADDR_ANALOG_RES;
    if (code == CHAN_THERMAL)
      idx = ADDR_THERMAL_RES;
    else if (code >= CHAN_PRESS2)
      idx = 4'(ADDR_Y_RESULT + 4'(3'h7 - code));
    return idx;
  endfunction
  // sample window ticks minus one for a channel
  function automatic logic [15:0] window_load(input logic [2:0] code, input logic [1:0] sample_window_time);
    logic [15:0] ticks;
    ticks = 16'(ACQ_BASE_TICKS << sample_window_time);
    if (code == CHAN_THERMAL)
      ticks = 16'(THERMAL_ACQ_TICKS);
    return 16'(ticks - 16'h0001);
  endfunction
  // settle count minus one; a zero field still costs one tick
  function automatic logic [15:0] settle_load(input logic [3:0] field);
    logic [15:0] ticks;
    ticks = 16'(field * SETTLE_STEP_TICKS);
    if (ticks == 16'h0000)
      ticks = 16'h0001;
    return 16'(ticks - 16'h0001);
  endfunction

  // ****************************************
  // state
  // ****************************************
  seq_regs_t   cur;           // registered state
  seq_regs_t   next_cur;      // next state
  logic [15:0] primary;       // views of the control words
  logic [15:0] secondary;
  logic [15:0] limit_sel;
  logic [1:0]  mode;
  logic [1:0]  rank_sel;
  logic [3:0]  rank_count;    // samples per channel minus one
  logic        pin_data;      // pin level after polarity
  logic        irq_set;
  logic        irq_clear;
  logic        start_req;
  logic        abort_req;
  logic        done;          // current wait finished this cycle
  logic [7:1]  left;          // channels remaining after current
  logic [2:0]  upcoming;

  assign primary   = cur.regs[ADDR_PRIMARY];
  assign secondary = cur.regs[ADDR_SECONDARY];
  assign limit_sel = cur.regs[ADDR_LIMIT_SELECT];
  assign mode      = primary[PRI_MODE_LSB +: 2];
  assign rank_sel  = secondary[SEC_RANK_LSB +: 2];
  // depth 1, 4, 8 or 16
  assign rank_count = (rank_sel == 2'h0) ? 4'h0 : 4'((5'h02 << rank_sel) - 5'h01);
  // active-low polarity inverts the pin
  assign pin_data  = cur.pin_sync ~^ secondary[SEC_PIN_POL];

  // ****************************************
  // next state
  // ****************************************

  // one process builds the whole next state
  always_comb
  begin
    next_cur            = cur;
    next_cur.conv_start = 1'b0;
    next_cur.rvalid     = 1'b0;
    start_req           = 1'b0;
    abort_req           = 1'b0;
    irq_set             = 1'b0;
    irq_clear           = 1'b0;
    left                = cur.pending;
    upcoming            = CHAN_NONE;
    // two-stage pin synchroniser
    next_cur.pin_meta  = gpio_in;
    next_cur.pin_sync  = cur.pin_meta;
    next_cur.pin_prev  = cur.pin_sync;
    next_cur.func_prev = secondary[SEC_PIN_FUNC];
    // input mode: data bit follows the pin
    if (secondary[SEC_PIN_FUNC] && secondary[SEC_PIN_DIR])
      next_cur.regs[ADDR_SECONDARY][SEC_PIN_DATA] = pin_data;
    // register writes; results and part code ignore writes
    if (reg_wr)
    begin
      if (reg_addr <= ADDR_LAST_RW)
      begin
        next_cur.regs[reg_addr] = reg_wdata;
        // data bit read-only in input mode
        if (reg_addr == ADDR_SECONDARY && secondary[SEC_PIN_DIR])
          next_cur.regs[ADDR_SECONDARY][SEC_PIN_DATA] = secondary[SEC_PIN_DATA];
      end
      // writing the mode starts or stops the sequencer
      if (reg_addr == ADDR_PRIMARY)
      begin
        start_req = (reg_wdata[PRI_MODE_LSB +: 2] != MODE_OFF);
        abort_req = !start_req;
      end
    end
    // read answer one cycle after the strobe
    if (reg_rd)
    begin
      next_cur.rvalid = 1'b1;
      if (reg_addr == ADDR_PART_CODE)
        next_cur.rdata = PART_CODE_VALUE;
      else if (reg_addr < ADDR_PART_CODE)
        next_cur.rdata = cur.regs[reg_addr];
      else
        next_cur.rdata = RESET_ZERO;
    end
    // pin output and interrupt
    // pin driven only in general-purpose output mode
    next_cur.gpio_oe  = secondary[SEC_PIN_FUNC] && !secondary[SEC_PIN_DIR];
    next_cur.gpio_out = secondary[SEC_PIN_DATA] ~^ secondary[SEC_PIN_POL];
    // disable bit blocks the pin source
    // set data bit with limit function on
    irq_set = secondary[SEC_PIN_FUNC] && secondary[SEC_PIN_DIR] && pin_data &&
              primary[PRI_LIMIT_IRQ_EN] && !limit_sel[LIM_PIN_IRQ_OFF];
    // level or enable change is the only clear
    irq_clear = (cur.pin_sync != cur.pin_prev) ||
                (secondary[SEC_PIN_FUNC] != cur.func_prev);
    // a set in the clearing cycle wins
    if (irq_set)
      next_cur.irq_hold = 1'b1;
    else if (irq_clear)
      next_cur.irq_hold = 1'b0;
    next_cur.int_n = !next_cur.irq_hold;
    // tick divider
    // half-microsecond enable from the clock
    next_cur.tick = 1'b0;
    if (cur.tick_cnt == 7'(TICK_CYCLES - 1))
    begin
      next_cur.tick_cnt = 7'h00;
      next_cur.tick     = 1'b1;
    end
    else
      next_cur.tick_cnt = 7'(cur.tick_cnt + 7'h01);
    done = cur.tick && (cur.wait_cnt == 16'h0000);
    if (cur.tick && cur.wait_cnt != 16'h0000)
      next_cur.wait_cnt = 16'(cur.wait_cnt - 16'h0001);
    // sequencer
    unique case (cur.state)
      // wait for a start
      S_IDLE: next_cur.busy = 1'b0;
      S_SETTLE:
      begin
        if (done)
        begin
          next_cur.state    = S_ACQ;
          next_cur.wait_cnt = window_load(cur.chan, primary[PRI_ACQ_LSB +: 2]);
        end
      end
      // sample window, then kick the converter
      S_ACQ:
      begin
        if (done)
        begin
          next_cur.state        = S_CONV;
          next_cur.wait_cnt     = 16'(CONV_TICKS - 1);
          next_cur.conv_start   = 1'b1;
          next_cur.conv_channel = cur.chan;
        end
      end
      // conversion, result taken at its end
      S_CONV:
      begin
        if (done)
        begin
          next_cur.regs[result_index(cur.chan)] = {4'h0, adc_data};
          next_cur.state = S_SORT;
          // sort only when the filter is on
          if (rank_sel != 2'h0)
            next_cur.wait_cnt = 16'(SORT_TICKS - 1);
        end
      end
      // sort step; with the filter off it passes in one cycle
      S_SORT:
      begin
        if (done || rank_sel == 2'h0)
        begin
          if (cur.sample != rank_count)
          begin
            next_cur.sample   = 4'(cur.sample + 4'h1);
            next_cur.state    = S_ACQ;
            next_cur.wait_cnt = window_load(cur.chan, primary[PRI_ACQ_LSB +: 2]);
          end
          else
          begin
            left[cur.chan] = 1'b0;
            upcoming       = top_channel(left);
            next_cur.pending = left;
            next_cur.sample  = 4'h0;
            next_cur.chan    = upcoming;
            if (upcoming == CHAN_NONE)
            begin
              // final settle after the last measurement
              next_cur.state    = S_END_SETTLE;
              next_cur.wait_cnt = settle_load(secondary[SEC_SETTLE_LSB +: 4]);
            end
            else if (upcoming >= CHAN_PRESS2)
            begin
              next_cur.state    = S_SETTLE;
              next_cur.wait_cnt = settle_load(secondary[SEC_SETTLE_LSB +: 4]);
            end
            else
            begin
              next_cur.state    = S_ACQ;
              next_cur.wait_cnt = window_load(upcoming, primary[PRI_ACQ_LSB +: 2]);
            end
          end
        end
      end
      // closing settle, then the interval timer
      S_END_SETTLE:
      begin
        if (done)
        begin
          next_cur.state    = S_TIMER;
          next_cur.wait_cnt = 16'(primary[PRI_TIMER_LSB +: 8] * TIMER_STEP_TICKS);
        end
      end
      S_TIMER:
      begin
        if (done)
        begin
          next_cur.state = S_IDLE;
          next_cur.busy  = 1'b0;
          // master mode reruns the sequence on its own
          start_req = (mode == MODE_MASTER);
        end
      end
    endcase
    // abort takes priority over any running step, except a master rerun starting at the end of the timer in the same cycle
    if (abort_req)
    begin
      next_cur.state = S_IDLE;
      next_cur.busy  = 1'b0;
    end
    // start: load channel set and enter first channel
    if (start_req)
    begin
      left = limit_sel[LIM_CHAN_LSB +: 7];
      // single mode converts the manual channel only
      if ((reg_wr && reg_addr == ADDR_PRIMARY ?
           reg_wdata[PRI_MODE_LSB +: 2] : mode) == MODE_SINGLE)
      begin
        left = 7'h00;
        if (reg_wdata[PRI_CHAN_LSB +: 3] != CHAN_NONE)
          left[reg_wdata[PRI_CHAN_LSB +: 3]] = 1'b1;
      end
      upcoming         = top_channel(left);
      next_cur.pending = left;
      next_cur.chan    = upcoming;
      next_cur.sample  = 4'h0;
      if (upcoming != CHAN_NONE)
      begin
        next_cur.busy     = 1'b1;
        // settle before the first channel always
        next_cur.state    = S_SETTLE;
        next_cur.wait_cnt = settle_load(secondary[SEC_SETTLE_LSB +: 4]);
      end
      else
        next_cur.state = S_IDLE;
    end
  end

  // ****************************************
  // state register
  // ****************************************

  // synchronous reset to documented values
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cur       <= '0;
      cur.int_n <= 1'b1;
      cur.regs[ADDR_SECONDARY] <= RESET_SECONDARY;
      cur.state <= S_IDLE;
    end
    else
      cur <= next_cur;
  end
  // outputs straight from the state register
  assign reg_rdata    = cur.rdata;
  assign reg_rvalid   = cur.rvalid;
  assign gpio_out     = cur.gpio_out;
  assign gpio_oe      = cur.gpio_oe;
  assign conv_start   = cur.conv_start;
  assign conv_channel = cur.conv_channel;
  assign seq_busy     = cur.busy;
  assign int_n        = cur.int_n;
endmodule

/* touch_seq_host.sv */
// host model: word reads and writes on the register port
// assumes a shared clk; strobes rise 1 ns after an edge, fall 1 ns after the taking edge
`timescale 1ns/1ps

module touch_seq_host
  import touch_seq_pkg::*;
(
  input  wire logic        clk,
  output logic      [3:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  // ****************************************
  // bus cycles
  // ****************************************
  // idle values at time zero
  initial
  begin
    reg_addr = 4'hF;
    reg_wdata = 16'hFFFF;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    if (a > ADDR_PART_CODE)
      return;
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;  // released lines must not keep the old word
  endtask

  // data and valid are taken 1 ns after the read edge
  task automatic rd(input logic [3:0] a, output logic [15:0] d, output logic v);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule

/* touch_seq_props.sv */
// checker for the sequencer ports, bound into touch_seq
// assumes one clock domain with synchronous reset
`timescale 1ns/1ps

module touch_seq_props
  import touch_seq_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        gpio_in,
  input wire logic        gpio_oe,
  input wire logic        conv_start,
  input wire logic        seq_busy,
  input wire logic        int_n
);
  // ****************************************
  // helpers and properties
  // ****************************************
  // shortest legal spacing of window ends, less three ticks of phase slack
  localparam int MIN_GAP = (CONV_TICKS + ACQ_BASE_TICKS - 3) * TICK_CYCLES;
  logic [15:0] gap;  // cycles since last conversion start

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // saturates so an idle spell never wraps into a false short gap
  always_ff @(posedge clk)
    if (reset)
      gap <= 16'hFFFF;
    else if (conv_start)
      gap <= 16'h0000;
    else if (gap != 16'hFFFF)
      gap <= gap + 16'h0001;

  rvalid_pulse_a: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer not one cycle after request");
  part_code_a: assert property (
    reg_rd && reg_addr == ADDR_PART_CODE |=> reg_rdata == PART_CODE_VALUE)
    else $error("part code read wrong");
  oe_no_int_a: assert property ($fell(int_n) |-> !gpio_oe)
    else $error("pin interrupt while pin drives");
  int_release_a: assert property ($rose(int_n) |->
    $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3) || $past(gpio_in, 2) != $past(gpio_in, 3)
    || $past(gpio_in, 3) != $past(gpio_in, 4)) else $error("interrupt cleared without cause");
  start_a: assert property (reg_wr && reg_addr == ADDR_PRIMARY &&
    reg_wdata[11:10] == MODE_SINGLE && reg_wdata[14:12] != CHAN_NONE |=> seq_busy)
    else $error("sequence did not start");
  abort_a: assert property (
    reg_wr && reg_addr == ADDR_PRIMARY && reg_wdata[11:10] == MODE_OFF |=> !seq_busy)
    else $error("sequence did not stop");
  conv_busy_a: assert property (conv_start |-> seq_busy)
    else $error("conversion outside sequence");
  settle_first_a: assert property ($rose(seq_busy) |-> !conv_start [*8])
    else $error("conversion without settling");
  conv_gap_a: assert property (conv_start |-> gap >= MIN_GAP)
    else $error("measurements too close");
endmodule

bind touch_seq touch_seq_props props (.clk(clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .gpio_in(gpio_in), .gpio_oe(gpio_oe), .conv_start(conv_start),
  .seq_busy(seq_busy), .int_n(int_n));

/* test_touch_seq.sv */
// self-checking bench for touch_seq, host model on the register port
// assumes a 250 MHz clock; pin and converter data are driven here
`timescale 1ns/1ps

module test_touch_seq
  import touch_seq_pkg::*;
;
  // ****************************************
  // signals, instances, common tasks
  // ****************************************
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic        gpio_in = 1'b0;
  logic        gpio_out;
  logic        gpio_oe;
  logic [11:0] adc_data = 12'h3C5;
  logic        conv_start;
  logic [2:0]  conv_channel;
  logic        seq_busy;
  logic        int_n;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cycles = 0;   // run length for the hang limit

  always #2 clk = ~clk;

  touch_seq_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  touch_seq dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .adc_data(adc_data),
    .conv_start(conv_start), .conv_channel(conv_channel), .seq_busy(seq_busy), .int_n(int_n));

  task automatic give_verdict();
    if (fail_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  // reads a word and compares it with its valid flag
  task automatic rd_check(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    host.rd(a, d, v);
    check("read_valid", v, 1'b1);
    check("read_word", d, exp);
  endtask

  // the sequence is slow, so the limit sits well above its sum
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset_map();
    logic [15:0] exp;
    for (int i = 0; i < 16; i++)
    begin
      exp = (i == 2) ? RESET_SECONDARY : (i == 14) ? PART_CODE_VALUE : RESET_ZERO;
      rd_check(i[3:0], exp);
    end
  endtask

  task automatic test_rw_limits();
    host.wr(4'h6, 16'hA55A);
    host.wr(4'h7, 16'h5AA5);
    host.wr(4'hD, 16'hFFFF);
    rd_check(4'h6, 16'hA55A);
    rd_check(4'h7, 16'h5AA5);
    rd_check(4'hD, 16'h0000);
  endtask

  // pin level change then settle past the synchroniser
  task automatic pin(input logic lvl);
    gpio_in = lvl;
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic test_pin_irq();
    host.wr(ADDR_PRIMARY, 16'h8000);
    host.wr(ADDR_LIMIT_SELECT, 16'h0000);
    host.wr(ADDR_SECONDARY, 16'h2C00);
    pin(1'b1);
    check("int_n_set", int_n, 1'b0);
    rd_check(ADDR_SECONDARY, 16'h3C00);
    host.wr(ADDR_LIMIT_SELECT, 16'h1000);
    pin(1'b1);
    check("int_n_held", int_n, 1'b0);
    pin(1'b0);
    check("int_n_clear", int_n, 1'b1);
    pin(1'b1);
    check("int_n_masked", int_n, 1'b1);
    host.wr(ADDR_LIMIT_SELECT, 16'h0000);
    pin(1'b1);
    check("int_n_unmask", int_n, 1'b0);
    host.wr(ADDR_SECONDARY, 16'h0C00);
    pin(1'b1);
    check("int_n_func", int_n, 1'b1);
    host.wr(ADDR_SECONDARY, 16'h3400);
    pin(1'b0);
    pin(1'b1);
    check("int_n_output", int_n, 1'b1);
    check("pin_oe", gpio_oe, 1'b1);
    check("pin_level", gpio_out, 1'b1);
  endtask

  // one sequence run, timed from busy rise to fall in ticks, conversions counted
  task automatic run_seq(input logic [15:0] ctl, input int ticks, input int convs,
                         input logic [3:0] res);
    int cyc;
    int seen;
    int diff;
    cyc = 0;
    seen = 0;
    adc_data = adc_data + 12'h111;
    host.wr(ADDR_PRIMARY, ctl);
    check("busy_rise", seq_busy, 1'b1);
    while (seq_busy === 1'b1 && cyc < 30000)
    begin
      @(posedge clk);
      #1;
      cyc++;
      if (conv_start === 1'b1)
        seen++;
    end
    diff = cyc / TICK_CYCLES - ticks;
    check("seq_ticks", diff >= -3 && diff <= 3, 1'b1);
    check("conv_count", seen, convs);
    rd_check(res, {4'h0, adc_data});
  endtask

  task automatic test_seq_timing();
    host.wr(ADDR_SECONDARY, 16'h0000);
    run_seq(16'h1400, 50, 1, ADDR_THERMAL_RES);
    run_seq(16'h4500, 26, 1, ADDR_P2_RESULT);
    host.wr(ADDR_SECONDARY, 16'h0020);
    run_seq(16'h4500, 111, 4, ADDR_P2_RESULT);
    host.wr(ADDR_SECONDARY, 16'h0000);
    run_seq(16'h1401, 122, 1, ADDR_THERMAL_RES);
  endtask

  // slave sequence over a channel mask, then master reruns until aborted
  task automatic test_abort();
    int seen;
    seen = 0;
    host.wr(ADDR_LIMIT_SELECT, 16'h0082);
    run_seq(16'h0800, 69, 2, ADDR_THERMAL_RES);
    host.wr(ADDR_LIMIT_SELECT, 16'h0002);
    host.wr(ADDR_PRIMARY, 16'h0C00);
    // two update periods of about fifty ticks each fit in this spell
    repeat (13750)
    begin
      @(posedge clk);
      #1;
      if (conv_start === 1'b1)
        seen++;
    end
    check("master_convs", seen, 2);
    check("conv_chan", conv_channel, CHAN_THERMAL);
    check("busy_run", seq_busy, 1'b1);
    host.wr(ADDR_PRIMARY, 16'h0000);
    check("busy_abort", seq_busy, 1'b0);
  endtask

  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    test_reset_map();
    test_rw_limits();
    test_pin_irq();
    test_seq_timing();
    test_abort();
    give_verdict();
  end
endmodule
